/* File: rtl/dram_lp_defs.vh */
// Constants of the DRAM low-power clock control block.
// Included by rtl/dram_lp_ctrl.v; holds definitions only.
`ifndef DRAM_LP_DEFS_VH
`define DRAM_LP_DEFS_VH

// Register byte offsets
`define LP_ADR_CTRL 8'h00
`define LP_ADR_TIMER 8'h04
`define LP_ADR_WAKE 8'h08
`define LP_ADR_DIRECT 8'h0c
`define LP_ADR_STATUS 8'h10

// Reset values
`define LP_CTRL_RST 32'h00000000
`define LP_TIMER_RST 32'h00040100
`define LP_WAKE_RST 32'h00043210

// Control register bits
`define LP_CTRL_AUTO_PD 0
`define LP_CTRL_AUTO_SR 1
`define LP_CTRL_CLK_STOP 2
`define LP_CTRL_MPD_EN 3
`define LP_CTRL_GEARDOWN 4
`define LP_CTRL_SW_LP 5
`define LP_CTRL_CFG 6
`define LP_CTRL_MUX_PAIR 7

// Timer fields: idle cycles before powerdown, refresh periods before self-refresh
`define LP_TIM_PD_LO 0
`define LP_IDLE_W 16
`define LP_TIM_SR_LO 16
`define LP_SRD_W 8

// Wake-up value fields, four bits each
`define LP_WK_W 4
`define LP_WK_IDLE 0
`define LP_WK_PD 4
`define LP_WK_CFG 8
`define LP_WK_SR 12
`define LP_WK_MPD 16

// Direct command fields
`define LP_DIR_PHY_PD 0
`define LP_DIR_WK_LO 4

// Memory command codes
`define LP_CMD_W 3
`define LP_CMD_NOP 3'h0
`define LP_CMD_SRE 3'h1
`define LP_CMD_SRX 3'h2
`define LP_CMD_PDE 3'h3
`define LP_CMD_PDX 3'h4
`define LP_CMD_MPDE 3'h5
`define LP_CMD_MPDX 3'h6

`endif

/* File: rtl/lp_sync2.v */
// Two flip-flop synchroniser for one level from another clock domain.
// Assumes the reset is synchronous to clk_i and active high.
`timescale 1ns/100ps
`default_nettype none

module lp_sync2 #(
  parameter [0:0] RST_VAL = 1'b1
) (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output wire q_o
);

  reg meta_q;
  reg sync_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

`default_nettype wire

/* File: rtl/dram_lp_ctrl.v */
// DRAM low-power clock control: two Q-channel handshakes, SDRAM power
// state sequencing, automatic powerdown and self-refresh, PHY powerdown.
// Assumes one clock, synchronous reset, classic Wishbone register access.
//
// Function
// - Main request: self-refresh first, then accept
// - Main handshake: active, request, accept, deny
// - Gear-down mode denies every main request
// - Software enters low power unless hardware owns self-refresh; leaves only its own
// - Programming handshake never denies, may delay
// - Only exit commands to chips in saving states
// - Commands plus clock enable move states
// - Per-chip clock and enable, DIMM mapping
// - Idle timer triggers automatic power saving
// - Clock-stop behaviour chosen by setting
// - Self-refresh delay counted in refresh periods
// - Automatic self-refresh exit only on system command
// - PHY powerdown with per-state wake-up value
// - Direct command requests PHY powerdown too
// - Q-channel sequence uses tie-off wake-up
// - Separate handshake stops programming clock
// - Cross-domain handshake inputs are synchronised
`timescale 1ns/100ps
`default_nettype none
`include "dram_lp_defs.vh"

module dram_lp_ctrl #(
  parameter CS_N = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire qreqn_i,
  output wire qactive_o,
  output wire qacceptn_o,
  output wire qdeny_o,
  input wire qreqn_apb_i,
  output wire qactive_apb_o,
  output wire qacceptn_apb_o,
  output wire qdeny_apb_o,
  input wire [3:0] q_wakeup_i,
  input wire sys_req_i,
  input wire [CS_N-1:0] sys_cs_i,
  output wire sys_grant_o,
  input wire refresh_tick_i,
  output wire [CS_N-1:0] cke_o,
  output wire [CS_N-1:0] mem_clk_en_o,
  output wire cmd_valid_o,
  output wire [2:0] cmd_o,
  output wire [CS_N-1:0] cmd_cs_o,
  output wire phy_lp_req_o,
  output wire [3:0] phy_lp_wakeup_o
);

  localparam [4:0] S_RUN = 5'b00001;
  localparam [4:0] S_CSTOP = 5'b00010;
  localparam [4:0] S_PD = 5'b00100;
  localparam [4:0] S_SR = 5'b01000;
  localparam [4:0] S_MPD = 5'b10000;
  localparam [4:0] Q_RUN = 5'b00001;
  localparam [4:0] Q_ENTER = 5'b00010;
  localparam [4:0] Q_STOP = 5'b00100;
  localparam [4:0] Q_EXIT = 5'b01000;
  localparam [4:0] Q_DENY = 5'b10000;
  localparam [1:0] P_RUN = 2'b01;
  localparam [1:0] P_STOP = 2'b10;
  localparam [1:0] SRC_Q = 2'd0;
  localparam [1:0] SRC_SW = 2'd1;
  localparam [1:0] SRC_AUTO = 2'd2;
  localparam [CS_N-1:0] ALL = {CS_N{1'b1}};

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  reg [31:0] ctrl_q;
  reg [31:0] timer_q;
  reg [31:0] wake_q;
  reg dir_pd_q;
  reg [3:0] dir_wk_q;
  reg ack_q;
  reg [31:0] rdat_q;
  reg [31:0] status;
  reg [7:0] sr8;
  reg [4:0] st_q;
  reg [4:0] q_q;
  reg [1:0] p_q;
  reg [1:0] src_q;
  reg [CS_N-1:0] cke_q;
  reg [CS_N-1:0] ck_q;
  reg [CS_N-1:0] sr_q;
  reg [`LP_CMD_W-1:0] cmd_q;
  reg [CS_N-1:0] cmd_cs_q;
  reg cmd_valid_q;
  reg [`LP_IDLE_W-1:0] idle_q;
  reg [`LP_SRD_W-1:0] rcnt_q;
  reg phy_req_q;
  reg [3:0] phy_wk_q;
  reg phy_req_d;
  reg [3:0] phy_wk_d;
  integer n;

  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wb_wr = wb_req & wb_we_i;

  function [31:0] bmerge(input [31:0] o, input [31:0] d, input [3:0] s);
    integer k;
    begin
      bmerge = o;
      for (k = 0; k < 4; k = k + 1) begin
        if (s[k]) begin
          bmerge[8*k +: 8] = d[8*k +: 8];
        end
      end
    end
  endfunction

  always @* begin
    sr8 = 8'h00;
    for (n = 0; n < CS_N; n = n + 1) begin
      sr8[n] = sr_q[n];
    end
    status = {sr8, 5'h00, phy_req_q, p_q, 3'h0, q_q, 3'h0, st_q};
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `LP_CTRL_RST;
      timer_q <= `LP_TIMER_RST;
      wake_q <= `LP_WAKE_RST;
      dir_pd_q <= 1'b0;
      dir_wk_q <= 4'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= wb_req;
      if (wb_wr) begin
        case (wb_adr_i)
          `LP_ADR_CTRL: ctrl_q <= bmerge(ctrl_q, wb_dat_i, wb_sel_i);
          `LP_ADR_TIMER: timer_q <= bmerge(timer_q, wb_dat_i, wb_sel_i);
          `LP_ADR_WAKE: wake_q <= bmerge(wake_q, wb_dat_i, wb_sel_i);
          `LP_ADR_DIRECT: begin
            if (wb_sel_i[0]) begin
              dir_pd_q <= wb_dat_i[`LP_DIR_PHY_PD];
              dir_wk_q <= wb_dat_i[`LP_DIR_WK_LO +: `LP_WK_W];
            end
          end
          default: ;
        endcase
      end
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `LP_ADR_CTRL: rdat_q <= ctrl_q;
          `LP_ADR_TIMER: rdat_q <= timer_q;
          `LP_ADR_WAKE: rdat_q <= wake_q;
          `LP_ADR_DIRECT: rdat_q <= {24'h000000, dir_wk_q, 3'h0, dir_pd_q};
          `LP_ADR_STATUS: rdat_q <= status;
          default: rdat_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

  wire auto_pd_en = ctrl_q[`LP_CTRL_AUTO_PD];
  wire auto_sr_en = ctrl_q[`LP_CTRL_AUTO_SR];
  wire clk_stop_en = ctrl_q[`LP_CTRL_CLK_STOP];
  wire mpd_en = ctrl_q[`LP_CTRL_MPD_EN];
  wire geardown = ctrl_q[`LP_CTRL_GEARDOWN];
  wire sw_lp = ctrl_q[`LP_CTRL_SW_LP];
  wire cfg_mode = ctrl_q[`LP_CTRL_CFG];
  wire mux_pair = ctrl_q[`LP_CTRL_MUX_PAIR];
  wire [`LP_IDLE_W-1:0] pd_lim = timer_q[`LP_TIM_PD_LO +: `LP_IDLE_W];
  wire [`LP_SRD_W-1:0] sr_lim = timer_q[`LP_TIM_SR_LO +: `LP_SRD_W];

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised handshake requests

  wire qreqn_s;
  wire qreqn_apb_s;

  lp_sync2 #(.RST_VAL(1'b1)) u_sync_q (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(qreqn_i),
    .q_o(qreqn_s)
  );

  lp_sync2 #(.RST_VAL(1'b1)) u_sync_qp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(qreqn_apb_i),
    .q_o(qreqn_apb_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Idle and refresh-period timers

  wire idle_ok = st_q[0] | st_q[1] | st_q[2];
  wire auto_pd = auto_pd_en & st_q[0] & ~sys_req_i & (idle_q >= pd_lim);
  wire sr_hit = auto_sr_en & idle_ok & ~sys_req_i & (rcnt_q >= sr_lim);

  always @(posedge clk_i) begin
    if (rst_i | sys_req_i | ~st_q[0]) begin
      idle_q <= {`LP_IDLE_W{1'b0}};
    end else if (idle_q < pd_lim) begin
      idle_q <= idle_q + 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i | sys_req_i | ~idle_ok) begin
      rcnt_q <= {`LP_SRD_W{1'b0}};
    end else if (refresh_tick_i & (rcnt_q != {`LP_SRD_W{1'b1}})) begin
      rcnt_q <= rcnt_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main-clock Q-channel

  wire q_enter = q_q[1];

  always @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= Q_RUN;
    end else begin
      case (q_q)
        Q_RUN: if (~qreqn_s) q_q <= geardown ? Q_DENY : Q_ENTER;
        Q_ENTER: if (st_q[3] & (src_q == SRC_Q)) q_q <= Q_STOP;
        Q_STOP: if (qreqn_s) q_q <= Q_EXIT;
        Q_EXIT: if (st_q[0]) q_q <= Q_RUN;
        Q_DENY: if (qreqn_s) q_q <= Q_RUN;
        default: q_q <= Q_RUN;
      endcase
    end
  end

  assign qacceptn_o = ~(q_q[2] | q_q[3]);
  assign qdeny_o = q_q[4];
  // Software-owned sleep; hardware-owned self-refresh needs no wake hint
  wire sw_low = (st_q[3] | st_q[4]) & (src_q == SRC_SW);
  assign qactive_o = sys_req_i | (wb_cyc_i & wb_stb_i) | (sw_lp ^ sw_low);

  ////////////////////////////////////////////////////////////////////////////
  // Programming-clock Q-channel

  always @(posedge clk_i) begin
    if (rst_i) begin
      p_q <= P_RUN;
    end else begin
      case (p_q)
        P_RUN: if (~qreqn_apb_s & ~wb_cyc_i & ~ack_q) p_q <= P_STOP;
        P_STOP: if (qreqn_apb_s) p_q <= P_RUN;
        default: p_q <= P_RUN;
      endcase
    end
  end

  assign qacceptn_apb_o = ~p_q[1];
  assign qdeny_apb_o = 1'b0;
  assign qactive_apb_o = (wb_cyc_i & wb_stb_i) | q_q[1] | q_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // SDRAM power state sequencer

  wire wake = sys_req_i | q_enter | sw_lp | sr_hit;
  wire [CS_N-1:0] sys_sr = sys_cs_i & sr_q;
  wire sr_all_exit = ((src_q == SRC_Q) & q_q[3]) | ((src_q == SRC_SW) & ~sw_lp);

  always @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= S_RUN;
      src_q <= SRC_AUTO;
      cke_q <= ALL;
      ck_q <= ALL;
      sr_q <= {CS_N{1'b0}};
      cmd_q <= `LP_CMD_NOP;
      cmd_cs_q <= {CS_N{1'b0}};
      cmd_valid_q <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      case (st_q)
        S_RUN: begin
          if (q_enter | sw_lp | sr_hit) begin
            cmd_valid_q <= 1'b1;
            cmd_cs_q <= ALL;
            cke_q <= {CS_N{1'b0}};
            if (sw_lp & mpd_en & ~q_enter) begin
              st_q <= S_MPD;
              src_q <= SRC_SW;
              cmd_q <= `LP_CMD_MPDE;
            end else begin
              st_q <= S_SR;
              sr_q <= ALL;
              cmd_q <= `LP_CMD_SRE;
              src_q <= q_enter ? SRC_Q : (sw_lp ? SRC_SW : SRC_AUTO);
            end
          end else if (auto_pd) begin
            if (clk_stop_en) begin
              st_q <= S_CSTOP;
              ck_q <= {CS_N{1'b0}};
            end else begin
              st_q <= S_PD;
              cke_q <= {CS_N{1'b0}};
              cmd_q <= `LP_CMD_PDE;
              cmd_cs_q <= ALL;
              cmd_valid_q <= 1'b1;
            end
          end
        end
        S_CSTOP: begin
          if (wake) begin
            st_q <= S_RUN;
            ck_q <= ALL;
          end
        end
        S_PD: begin
          if (wake) begin
            st_q <= S_RUN;
            cke_q <= ALL;
            cmd_q <= `LP_CMD_PDX;
            cmd_cs_q <= ALL;
            cmd_valid_q <= 1'b1;
          end
        end
        S_SR: begin
          if (sr_all_exit) begin
            st_q <= S_RUN;
            cke_q <= ALL;
            sr_q <= {CS_N{1'b0}};
            cmd_q <= `LP_CMD_SRX;
            cmd_cs_q <= sr_q;
            cmd_valid_q <= 1'b1;
          end else if ((src_q != SRC_Q) & sys_req_i & (|sys_sr)) begin
            cke_q <= cke_q | sys_sr;
            sr_q <= sr_q & ~sys_cs_i;
            cmd_q <= `LP_CMD_SRX;
            cmd_cs_q <= sys_sr;
            cmd_valid_q <= 1'b1;
            if ((sr_q & ~sys_cs_i) == {CS_N{1'b0}}) begin
              st_q <= S_RUN;
            end
          end
        end
        S_MPD: begin
          if (~sw_lp) begin
            st_q <= S_RUN;
            cke_q <= ALL;
            cmd_q <= `LP_CMD_MPDX;
            cmd_cs_q <= ALL;
            cmd_valid_q <= 1'b1;
          end
        end
        default: st_q <= S_RUN;
      endcase
    end
  end

  // Grant only to chips awake and clocked
  assign sys_grant_o = sys_req_i & (st_q[0] | (st_q[3] & (src_q != SRC_Q)))
    & ~(|(sys_cs_i & (sr_q | ~cke_q | ~ck_q)));

  ////////////////////////////////////////////////////////////////////////////
  // PHY powerdown request

  always @* begin
    phy_req_d = 1'b1;
    phy_wk_d = wake_q[`LP_WK_IDLE +: `LP_WK_W];
    if ((q_q[1] & st_q[3]) | q_q[2]) begin
      phy_wk_d = q_wakeup_i;
    end else if (dir_pd_q) begin
      phy_wk_d = dir_wk_q;
    end else begin
      case (st_q)
        S_CSTOP: phy_wk_d = wake_q[`LP_WK_IDLE +: `LP_WK_W];
        S_PD: phy_wk_d = wake_q[`LP_WK_PD +: `LP_WK_W];
        S_SR: phy_wk_d = wake_q[`LP_WK_SR +: `LP_WK_W];
        S_MPD: phy_wk_d = wake_q[`LP_WK_MPD +: `LP_WK_W];
        default: begin
          phy_req_d = cfg_mode;
          phy_wk_d = cfg_mode ? wake_q[`LP_WK_CFG +: `LP_WK_W] : phy_wk_d;
        end
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      phy_req_q <= 1'b0;
      phy_wk_q <= 4'h0;
    end else begin
      phy_req_q <= phy_req_d;
      phy_wk_q <= phy_wk_d;
    end
  end

  assign phy_lp_req_o = phy_req_q;
  assign phy_lp_wakeup_o = phy_wk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Per-chip outputs with DIMM pairing option

  genvar g;
  generate
    for (g = 0; g < CS_N; g = g + 1) begin : g_cs
      assign cke_o[g] = mux_pair ? cke_q[(g/2)*2] : cke_q[g];
      assign mem_clk_en_o[g] = mux_pair ? ck_q[(g/2)*2] : ck_q[g];
      assign cmd_cs_o[g] = mux_pair ? cmd_cs_q[(g/2)*2] : cmd_cs_q[g];
    end
  endgenerate

  assign cmd_valid_o = cmd_valid_q;
  assign cmd_o = cmd_q;

endmodule

`default_nettype wire

/* File: verification/dram_lp_checker.sv */
// Port checker for the DRAM low-power control block.
// Bound onto every dram_lp_ctrl instance; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
`include "dram_lp_defs.vh"
module dram_lp_checker #(
  parameter CS_N = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire qreqn_i,
  input wire qactive_o,
  input wire qacceptn_o,
  input wire qdeny_o,
  input wire qreqn_apb_i,
  input wire qactive_apb_o,
  input wire qacceptn_apb_o,
  input wire qdeny_apb_o,
  input wire [3:0] q_wakeup_i,
  input wire [CS_N-1:0] cke_o,
  input wire cmd_valid_o,
  input wire [2:0] cmd_o,
  input wire phy_lp_req_o,
  input wire [3:0] phy_lp_wakeup_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  sequence s_sre;
    cmd_valid_o && cmd_o == `LP_CMD_SRE && !qreqn_i;
  endsequence
  sequence s_accept_soon;
    ##[1:4] !qacceptn_o;
  endsequence
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held over one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  chk_prog_deny: assert property (!qdeny_apb_o)
    else $error("programming channel denied");
  chk_accept_sr: assert property ($fell(qacceptn_o) |-> cke_o == {CS_N{1'b0}})
    else $error("accept while chips awake");
  chk_sre_accept: assert property (s_sre |-> s_accept_soon)
    else $error("no accept after self-refresh entry");
  chk_stop_cmds: assert property (cmd_valid_o && !qacceptn_o |-> cmd_o == `LP_CMD_SRX)
    else $error("command other than exit while stopped");
  chk_exit_awake: assert property ($rose(qacceptn_o) |-> cke_o == {CS_N{1'b1}})
    else $error("accept withdrawn before chips awake");
  chk_deny_cause: assert property ($rose(qdeny_o) |-> !$past(qreqn_i, 2) && qacceptn_o)
    else $error("deny without request");
  chk_phy_tieoff: assert property ($fell(qacceptn_o) |->
    phy_lp_req_o && phy_lp_wakeup_o == q_wakeup_i)
    else $error("wrong PHY request at accept");
  chk_prog_wait: assert property ($fell(qacceptn_apb_o) |-> !$past(qreqn_apb_i, 2))
    else $error("programming accept without synced request");
  chk_busy_hint: assert property (wb_cyc_i && wb_stb_i |-> qactive_o && qactive_apb_o)
    else $error("active hint missing during bus access");
endmodule
bind dram_lp_ctrl dram_lp_checker #(.CS_N(CS_N)) i_dram_lp_checker (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .qreqn_i(qreqn_i), .qactive_o(qactive_o), .qacceptn_o(qacceptn_o), .qdeny_o(qdeny_o),
  .qreqn_apb_i(qreqn_apb_i), .qactive_apb_o(qactive_apb_o),
  .qacceptn_apb_o(qacceptn_apb_o), .qdeny_apb_o(qdeny_apb_o), .q_wakeup_i(q_wakeup_i),
  .cke_o(cke_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .phy_lp_req_o(phy_lp_req_o),
  .phy_lp_wakeup_o(phy_lp_wakeup_o));
`default_nettype wire

/* File: verification/qch_partner.sv */
// External power controller for one Q-channel.
// Assumes the controlled block answers on clk_i.
`timescale 1ns/100ps
`default_nettype none
module qch_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic active_i,
  input wire logic acceptn_i,
  input wire logic deny_i,
  output var logic reqn_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      reqn_o <= 1'b1;
    end else if (reqn_o && go_i && !active_i && acceptn_i && !deny_i) begin
      reqn_o <= 1'b0;
    end else if (!reqn_o && (!acceptn_i || deny_i) && (!go_i || active_i)) begin
      reqn_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/dram_lp_ctrl_test.sv */
// Self-checking bench for dram_lp_ctrl with two Q-channel partners.
// Assumes the design and its defines header are on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "dram_lp_defs.vh"
module dram_lp_ctrl_test;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic qreqn_i, qactive_o, qacceptn_o, qdeny_o, qreqn_apb_i, qactive_apb_o;
  logic qacceptn_apb_o, qdeny_apb_o, sys_grant_o, cmd_valid_o, phy_lp_req_o;
  logic sys_req_i = 1'b0, refresh_tick_i = 1'b0, go_main = 1'b0, go_prog = 1'b0;
  logic [3:0] q_wakeup_i = 4'h0, phy_lp_wakeup_o, cke_o, mem_clk_en_o, cmd_cs_o;
  logic [3:0] sys_cs_i = 4'h0, last_cs;
  logic [2:0] cmd_o;
  logic [31:0] exp_reg [0:2];
  logic [2:0] cmds [$];
  int num_errors = 0, checks = 0, i;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) refresh_tick_i <= ($urandom % 8) == 0;
  always @(posedge clk_i) begin
    if (!rst_i && cmd_valid_o) begin
      cmds.push_back(cmd_o);
      last_cs <= cmd_cs_o;
    end
  end
  dram_lp_ctrl #(.CS_N(4)) i_dram_lp_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .qreqn_i(qreqn_i), .qactive_o(qactive_o), .qacceptn_o(qacceptn_o), .qdeny_o(qdeny_o),
    .qreqn_apb_i(qreqn_apb_i), .qactive_apb_o(qactive_apb_o),
    .qacceptn_apb_o(qacceptn_apb_o), .qdeny_apb_o(qdeny_apb_o), .q_wakeup_i(q_wakeup_i),
    .sys_req_i(sys_req_i), .sys_cs_i(sys_cs_i), .sys_grant_o(sys_grant_o),
    .refresh_tick_i(refresh_tick_i), .cke_o(cke_o), .mem_clk_en_o(mem_clk_en_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .cmd_cs_o(cmd_cs_o),
    .phy_lp_req_o(phy_lp_req_o), .phy_lp_wakeup_o(phy_lp_wakeup_o));
  qch_partner i_qch_partner (.clk_i(clk_i), .rst_i(rst_i), .go_i(go_main),
    .active_i(qactive_o), .acceptn_i(qacceptn_o), .deny_i(qdeny_o), .reqn_o(qreqn_i));
  qch_partner i_qch_partner_apb (.clk_i(clk_i), .rst_i(rst_i), .go_i(go_prog),
    .active_i(qactive_apb_o), .acceptn_i(qacceptn_apb_o), .deny_i(qdeny_apb_o),
    .reqn_o(qreqn_apb_i));
  ////////////////////////////////////////
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic next_cmd(input logic [2:0] exp);
    @(posedge clk_i);
    if (cmds.size() == 0) begin
      cmp(32'hx, {29'h0, exp});
    end else begin
      cmp({29'h0, cmds.pop_front()}, {29'h0, exp});
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) begin
      num_errors++;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h7228));
    exp_reg = '{`LP_CTRL_RST, `LP_TIMER_RST, `LP_WAKE_RST};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (i = 0; i < 3; i++) begin
      wb(1'b0, 8'(i * 4), 32'h0);
      cmp(rd, exp_reg[i]);
    end
    exp_reg[1] = $urandom & 32'h00ffffff;
    exp_reg[2] = $urandom & 32'h000fffff;
    q_wakeup_i <= 4'($urandom);
    for (i = 1; i < 3; i++) begin
      wb(1'b1, 8'(i * 4), exp_reg[i]);
      wb(1'b0, 8'(i * 4), 32'h0);
      cmp(rd, exp_reg[i]);
    end
    wb(1'b1, 8'h14, 32'hffffffff);
    wb(1'b0, 8'h14, 32'h0);
    cmp(rd, 32'h0);
    $display("registers done");
    wb(1'b1, `LP_ADR_DIRECT, 32'h000000a1);
    for (i = 0; i < 40 && phy_lp_req_o !== 1'b1; i++) @(posedge clk_i);
    cmp({phy_lp_req_o, phy_lp_wakeup_o}, 32'h1a);
    wb(1'b1, `LP_ADR_DIRECT, 32'h0);
    $display("direct done");
    go_main <= 1'b1;
    for (i = 0; i < 40 && qacceptn_o !== 1'b0; i++) @(posedge clk_i);
    cmp(cke_o, 32'h0);
    cmp({qactive_o, phy_lp_req_o, phy_lp_wakeup_o}, {2'b01, q_wakeup_i});
    next_cmd(`LP_CMD_SRE);
    go_main <= 1'b0;
    for (i = 0; i < 40 && qacceptn_o !== 1'b1; i++) @(posedge clk_i);
    cmp(cke_o, 32'hf);
    next_cmd(`LP_CMD_SRX);
    $display("main channel done");
    go_prog <= 1'b1;
    for (i = 0; i < 40 && qacceptn_apb_o !== 1'b0; i++) @(posedge clk_i);
    cmp(qacceptn_apb_o, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    cmp(rd, 32'h0);
    go_prog <= 1'b0;
    for (i = 0; i < 40 && !(qacceptn_apb_o === 1'b1 && qreqn_apb_i); i++) @(posedge clk_i);
    cmp(qacceptn_apb_o, 32'h1);
    $display("programming channel done");
    wb(1'b1, `LP_ADR_CTRL, 32'h10);
    go_main <= 1'b1;
    for (i = 0; i < 40 && qdeny_o !== 1'b1; i++) @(posedge clk_i);
    cmp({qdeny_o, qacceptn_o}, 32'h3);
    go_main <= 1'b0;
    for (i = 0; i < 40 && qdeny_o !== 1'b0; i++) @(posedge clk_i);
    wb(1'b1, `LP_ADR_CTRL, 32'h30);
    for (i = 0; i < 40 && cke_o !== 4'h0; i++) @(posedge clk_i);
    cmp(cke_o, 32'h0);
    next_cmd(`LP_CMD_SRE);
    sys_req_i <= 1'b1;
    sys_cs_i <= 4'h1;
    for (i = 0; i < 40 && sys_grant_o !== 1'b1; i++) @(posedge clk_i);
    sys_req_i <= 1'b0;
    cmp(cke_o, 32'h1);
    next_cmd(`LP_CMD_SRX);
    wb(1'b1, `LP_ADR_CTRL, 32'h0);
    for (i = 0; i < 40 && cke_o !== 4'hf; i++) @(posedge clk_i);
    cmp(cke_o, 32'hf);
    next_cmd(`LP_CMD_SRX);
    $display("software path done");
    wb(1'b1, `LP_ADR_TIMER, 32'h00020010);
    wb(1'b1, `LP_ADR_CTRL, 32'h01);
    for (i = 0; i < 100 && cke_o !== 4'h0; i++) @(posedge clk_i);
    next_cmd(`LP_CMD_PDE);
    cmp({phy_lp_req_o, phy_lp_wakeup_o}, {1'b1, exp_reg[2][7:4]});
    sys_req_i <= 1'b1;
    sys_cs_i <= 4'h2;
    for (i = 0; i < 40 && sys_grant_o !== 1'b1; i++) @(posedge clk_i);
    next_cmd(`LP_CMD_PDX);
    wb(1'b1, `LP_ADR_CTRL, 32'h05);
    sys_req_i <= 1'b0;
    for (i = 0; i < 100 && mem_clk_en_o !== 4'h0; i++) @(posedge clk_i);
    @(posedge clk_i);
    cmp({cke_o, mem_clk_en_o}, 32'hf0);
    cmp({phy_lp_req_o, phy_lp_wakeup_o}, {1'b1, exp_reg[2][3:0]});
    sys_req_i <= 1'b1;
    for (i = 0; i < 40 && sys_grant_o !== 1'b1; i++) @(posedge clk_i);
    cmp({cke_o, mem_clk_en_o}, 32'hff);
    wb(1'b1, `LP_ADR_CTRL, 32'h82);
    sys_req_i <= 1'b0;
    for (i = 0; i < 300 && cke_o !== 4'h0; i++) @(posedge clk_i);
    next_cmd(`LP_CMD_SRE);
    cmp({phy_lp_req_o, phy_lp_wakeup_o}, {1'b1, exp_reg[2][15:12]});
    repeat (30) @(posedge clk_i);
    cmp(cke_o, 32'h0);
    sys_cs_i <= 4'h4;
    sys_req_i <= 1'b1;
    for (i = 0; i < 40 && sys_grant_o !== 1'b1; i++) @(posedge clk_i);
    next_cmd(`LP_CMD_SRX);
    cmp({cke_o, last_cs}, 32'hcc);
    sys_cs_i <= 4'hf;
    for (i = 0; i < 40 && cke_o !== 4'hf; i++) @(posedge clk_i);
    next_cmd(`LP_CMD_SRX);
    wb(1'b1, `LP_ADR_CTRL, 32'h28);
    sys_req_i <= 1'b0;
    for (i = 0; i < 40 && cke_o !== 4'h0; i++) @(posedge clk_i);
    next_cmd(`LP_CMD_MPDE);
    cmp({qactive_o, phy_lp_req_o, phy_lp_wakeup_o}, {2'b01, exp_reg[2][19:16]});
    wb(1'b1, `LP_ADR_CTRL, 32'h40);
    next_cmd(`LP_CMD_MPDX);
    cmp({cke_o, phy_lp_req_o, phy_lp_wakeup_o}, {4'hf, 1'b1, exp_reg[2][11:8]});
    $display("power saving done");
    give_verdict();
  end
endmodule
`default_nettype wire
